// [cmp_ref_params.svh]
// Offsets, field positions and reset values of the comparator block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef CMP_REF_PARAMS_SVH
`define CMP_REF_PARAMS_SVH

// Register byte offsets
`define CR_OFS_CMP        12'h000
`define CR_OFS_REF        12'h004
`define CR_OFS_STAT       12'h008
`define CR_OFS_MASK       12'h00C

// comparator_control fields
`define CR_CMP_IDLE       4'hF
`define CR_CMP_EVT_B      4'hD
`define CR_CMP_EVT_A      4'hC
`define CR_CMP_EN_B       4'hB
`define CR_CMP_EN_A       4'hA
`define CR_CMP_PAD_B      4'h9
`define CR_CMP_PAD_A      4'h8
`define CR_CMP_RES_B      4'h7
`define CR_CMP_RES_A      4'h6
`define CR_CMP_INV_B      4'h5
`define CR_CMP_INV_A      4'h4
`define CR_CMP_NEG_B      4'h3
`define CR_CMP_POS_B      4'h2
`define CR_CMP_NEG_A      4'h1
`define CR_CMP_POS_A      4'h0

// reference_control fields
`define CR_REF_PWR        3'h7
`define CR_REF_PIN        3'h6
`define CR_REF_RANGE      3'h5
`define CR_REF_SRC        3'h4
`define CR_REF_LVL_HI     3'h3
`define CR_REF_LVL_LO     3'h0

// Interrupt status and mask fields
`define CR_IRQ_A          1'h0
`define CR_IRQ_B          1'h1

// Reset values
`define CR_RST_CMP        16'h0000
`define CR_RST_REF        8'h00
`define CR_RST_IRQ        2'h0

`endif

// [cmp_ref_pkg.sv]
// Types shared by the comparator control block and its sync unit.
// Index 0 of every two-bit field is comparator a, index 1 comparator b.
`default_nettype none
package cmp_ref_pkg;

    typedef enum logic [2:0] {
        SEL_CMP,
        SEL_REF,
        SEL_STAT,
        SEL_MASK,
        SEL_NONE
    } reg_sel_type;

    typedef struct packed {
        logic        idle_stop;
        logic [1:0]  evt;
        logic [1:0]  en;
        logic [1:0]  pad_en;
        logic [1:0]  inv;
        logic [1:0]  neg;
        logic [1:0]  pos;
        logic [7:0]  ref_ctrl;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        irq;
        logic [1:0]  pad;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ctrl_state_type;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] res;
        logic [1:0] chg;
    } sync_state_type;

endpackage : cmp_ref_pkg
`default_nettype wire

// [cmp_sync_if.sv]
// Carries comparator raw levels, settings and results between the
// control block and its synchroniser unit. Single clock domain.
`default_nettype none
interface cmp_sync_if;
    logic [1:0] raw;
    logic [1:0] en;
    logic [1:0] inv;
    logic [1:0] result;
    logic [1:0] change;

    modport unit (
        input  raw,
        input  en,
        input  inv,
        output result,
        output change
    );
    modport ctrl (
        output raw,
        output en,
        output inv,
        input  result,
        input  change
    );
endinterface : cmp_sync_if
`default_nettype wire

// [cmp_sync_unit.sv]
// Synchronises the two analog comparator outputs and flags changes.
// Assumes raw levels are asynchronous; settings come from ref_clk_i.
`default_nettype none
module cmp_sync_unit
    import cmp_ref_pkg::*;
(
    input  wire logic  ref_clk_i,
    input  wire logic  rst_n_i,
    cmp_sync_if.unit   sif
);
    import cmp_ref_pkg::*;

    sync_state_type q;
    sync_state_type n;

    always_comb begin
        n    = q;
        n.s1 = sif.raw;
        n.s2 = q.s1;
        for (int i = 0; i < 2; i++) begin
            // Disabled comparator reads low and raises no event
            n.res[i] = sif.en[i] & (q.s2[i] ^ sif.inv[i]);
            n.chg[i] = sif.en[i] & (n.res[i] != q.res[i]);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign sif.result = q.res;
    assign sif.change = q.chg;

    a_result_invert_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        sif.en[0] |=> q.res[0] == ($past(q.s2[0]) ^ $past(sif.inv[0])))
        else $error("comparator a result not inversion of synced level");

    a_change_detect_b: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (sif.en[1] && $past(sif.en[1]) && $changed(q.res[1]))
            |-> q.chg[1])
        else $error("comparator b change not flagged");

endmodule : cmp_sync_unit
`default_nettype wire

// [cmp_ref_ctrl.sv]
// Control and status logic for two analog comparators and their
// programmable reference ladder, reached over a 32-bit APB slave.
// Assumes the analog cores, ladder and pads sit outside this module.
//
// Operation
// - With idle-stop set and the device idle, no interrupts are raised.
// - A comparator output change sets its event flag; software clears it.
// - Each comparator has its own enable bit.
// - Each comparator has a bit enabling its result onto its pad.
// - The read-only result bit shows pos above neg, reversed if inverted.
// - The inversion bit inverts the result before it is reported and used.
// - The negative-input select picks VIN+ when one and VIN- when zero.
// - The ladder power bit powers the reference ladder on or down.
// - The range bit picks the low 1/24 range when one, else 1/32 range.
// - The source bit picks external reference pins when one, else rails.
// - The 4-bit level code sets the reference level within the range.
// - Unimplemented bits and the reference upper byte read zero.
//
// Implementation choices: the register offsets and register access over APB.
`default_nettype none
`include "cmp_ref_params.svh"
module cmp_ref_ctrl
    import cmp_ref_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        idle_i,
    input  wire logic        cmp_a_raw_i,
    input  wire logic        cmp_b_raw_i,
    output logic             irq_o,
    output logic             cmp_a_enable_o,
    output logic             cmp_b_enable_o,
    output logic             cmp_a_pos_select_o,
    output logic             cmp_b_pos_select_o,
    output logic             cmp_a_neg_select_o,
    output logic             cmp_b_neg_select_o,
    output logic             cmp_a_pad_o,
    output logic             cmp_a_pad_oe_o,
    output logic             cmp_b_pad_o,
    output logic             cmp_b_pad_oe_o,
    output logic             ladder_power_enable_o,
    output logic             ladder_pin_enable_o,
    output logic             ladder_range_select_o,
    output logic             ladder_source_select_o,
    output logic      [3:0]  ladder_level_code_o
);
    import cmp_ref_pkg::*;

    ctrl_state_type q;
    ctrl_state_type n;
    reg_sel_type    sel;
    logic           setup;
    logic           wr;
    logic [1:0]     irq_set;
    logic [1:0]     irq_clr;
    logic [1:0]     evt_clr;

    cmp_sync_if sif ();

    cmp_sync_unit u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .sif       (sif)
    );

    assign sif.raw = {cmp_b_raw_i, cmp_a_raw_i};
    assign sif.en  = q.en;
    assign sif.inv = q.inv;

    function automatic reg_sel_type decode(input logic [11:0] addr);
        case (addr)
            `CR_OFS_CMP:  decode = SEL_CMP;
            `CR_OFS_REF:  decode = SEL_REF;
            `CR_OFS_STAT: decode = SEL_STAT;
            `CR_OFS_MASK: decode = SEL_MASK;
            default:      decode = SEL_NONE;
        endcase
    endfunction : decode

    // Everything not assigned here stays zero
    function automatic logic [15:0] cmp_word(input ctrl_state_type s,
                                             input logic [1:0] res);
        logic [15:0] w;
        w                = `CR_RST_CMP;
        w[`CR_CMP_IDLE]  = s.idle_stop;
        w[`CR_CMP_EVT_B] = s.evt[1];
        w[`CR_CMP_EVT_A] = s.evt[0];
        w[`CR_CMP_EN_B]  = s.en[1];
        w[`CR_CMP_EN_A]  = s.en[0];
        w[`CR_CMP_PAD_B] = s.pad_en[1];
        w[`CR_CMP_PAD_A] = s.pad_en[0];
        w[`CR_CMP_RES_B] = res[1];
        w[`CR_CMP_RES_A] = res[0];
        w[`CR_CMP_INV_B] = s.inv[1];
        w[`CR_CMP_INV_A] = s.inv[0];
        w[`CR_CMP_NEG_B] = s.neg[1];
        w[`CR_CMP_POS_B] = s.pos[1];
        w[`CR_CMP_NEG_A] = s.neg[0];
        w[`CR_CMP_POS_A] = s.pos[0];
        cmp_word = w;
    endfunction : cmp_word

    always_comb begin
        n       = q;
        sel     = decode(paddr_i);
        setup   = psel_i & ~penable_i;
        wr      = psel_i & penable_i & q.pready & pwrite_i;
        evt_clr = 2'h0;
        irq_clr = 2'h0;

        // Zero-wait slave: pready rises for exactly the access cycle
        n.pready  = setup;
        n.pslverr = setup & (sel == SEL_NONE);
        n.prdata  = 32'h0000_0000;
        if (setup && !pwrite_i) begin
            case (sel)
                SEL_CMP:  n.prdata = {16'h0000, cmp_word(q, sif.result)};
                SEL_REF:  n.prdata = {24'h00_0000, q.ref_ctrl};
                SEL_STAT: n.prdata = {30'h0000_0000, q.irq_stat};
                SEL_MASK: n.prdata = {30'h0000_0000, q.irq_mask};
                default:  n.prdata = 32'h0000_0000;
            endcase
        end

        if (wr) begin
            case (sel)
                SEL_CMP: begin
                    n.idle_stop = pwdata_i[`CR_CMP_IDLE];
                    n.en[1]     = pwdata_i[`CR_CMP_EN_B];
                    n.en[0]     = pwdata_i[`CR_CMP_EN_A];
                    n.pad_en[1] = pwdata_i[`CR_CMP_PAD_B];
                    n.pad_en[0] = pwdata_i[`CR_CMP_PAD_A];
                    n.inv[1]    = pwdata_i[`CR_CMP_INV_B];
                    n.inv[0]    = pwdata_i[`CR_CMP_INV_A];
                    n.neg[1]    = pwdata_i[`CR_CMP_NEG_B];
                    n.neg[0]    = pwdata_i[`CR_CMP_NEG_A];
                    n.pos[1]    = pwdata_i[`CR_CMP_POS_B];
                    n.pos[0]    = pwdata_i[`CR_CMP_POS_A];
                    // Writing zero clears an event flag
                    evt_clr[1]  = ~pwdata_i[`CR_CMP_EVT_B];
                    evt_clr[0]  = ~pwdata_i[`CR_CMP_EVT_A];
                end
                SEL_REF: begin
                    // Upper byte has no storage, writes there vanish
                    n.ref_ctrl = pwdata_i[7:0];
                end
                SEL_STAT: begin
                    irq_clr = pwdata_i[1:0];
                end
                SEL_MASK: begin
                    n.irq_mask = pwdata_i[1:0];
                end
                default: begin
                    n.irq_mask = q.irq_mask;
                end
            endcase
        end

        // A change in the clearing cycle wins over the clear
        n.evt = sif.change | (q.evt & ~evt_clr);
        irq_set = sif.change & ~{2{q.idle_stop & idle_i}};
        n.irq_stat = irq_set | (q.irq_stat & ~irq_clr);
        n.irq = |(n.irq_stat & n.irq_mask);
        n.pad = sif.result;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q           <= '0;
            q.ref_ctrl  <= `CR_RST_REF;
            q.irq_stat  <= `CR_RST_IRQ;
            q.irq_mask  <= `CR_RST_IRQ;
        end else begin
            q <= n;
        end
    end

    assign prdata_o  = q.prdata;
    assign pready_o  = q.pready;
    assign pslverr_o = q.pslverr;
    assign irq_o     = q.irq;

    assign cmp_a_enable_o     = q.en[0];
    assign cmp_b_enable_o     = q.en[1];
    assign cmp_a_pos_select_o = q.pos[0];
    assign cmp_b_pos_select_o = q.pos[1];
    assign cmp_a_neg_select_o = q.neg[0];
    assign cmp_b_neg_select_o = q.neg[1];
    assign cmp_a_pad_o        = q.pad[0];
    assign cmp_b_pad_o        = q.pad[1];
    assign cmp_a_pad_oe_o     = q.pad_en[0];
    assign cmp_b_pad_oe_o     = q.pad_en[1];

    // Analog ladder reads these bits directly; settling is its concern
    assign ladder_power_enable_o  = q.ref_ctrl[`CR_REF_PWR];
    assign ladder_pin_enable_o    = q.ref_ctrl[`CR_REF_PIN];
    assign ladder_range_select_o  = q.ref_ctrl[`CR_REF_RANGE];
    assign ladder_source_select_o = q.ref_ctrl[`CR_REF_SRC];
    assign ladder_level_code_o    =
        q.ref_ctrl[`CR_REF_LVL_HI:`CR_REF_LVL_LO];

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_idle_no_irq: assert property (
        (q.idle_stop && idle_i && !q.irq_stat[0] && !wr)
            |=> !q.irq_stat[0])
        else $error("interrupt status set while idle-stopped");

    a_event_flag_set: assert property (
        sif.change[1] |=> q.evt[1])
        else $error("comparator b change did not set its event flag");

    a_enable_write: assert property (
        (wr && sel == SEL_CMP)
            |=> cmp_a_enable_o == $past(pwdata_i[`CR_CMP_EN_A]))
        else $error("comparator a enable not taken from write");

    a_pad_enable_write: assert property (
        (wr && sel == SEL_CMP)
            ##1 !(wr && sel == SEL_CMP)
            |-> cmp_b_pad_oe_o == $past(pwdata_i[`CR_CMP_PAD_B]))
        else $error("comparator b pad enable not held");

    a_result_read: assert property (
        (psel_i && penable_i && pready_o && !pwrite_i && sel == SEL_CMP)
            |-> prdata_o[`CR_CMP_RES_A] == $past(sif.result[0]))
        else $error("comparator a result bit read wrong");

    a_neg_route: assert property (
        (wr && sel == SEL_CMP)
            |=> cmp_b_neg_select_o == $past(pwdata_i[`CR_CMP_NEG_B]))
        else $error("comparator b negative select not taken");

    a_level_code: assert property (
        (wr && sel == SEL_REF)
            |=> ladder_level_code_o == $past(pwdata_i[3:0])
                && ladder_range_select_o == $past(pwdata_i[5]))
        else $error("ladder level or range not taken from write");

    a_reserved_zero: assert property (
        (pready_o && !pwrite_i && sel != SEL_NONE)
            |-> prdata_o[31:16] == 16'h0000
                && prdata_o[`CR_CMP_IDLE - 4'h1] == 1'b0)
        else $error("unimplemented bits read nonzero");

    a_irq_level: assert property (
        irq_o == |(q.irq_stat & q.irq_mask))
        else $error("interrupt output disagrees with status and mask");

    a_pos_route: assert property (
        (wr && sel == SEL_CMP)
            |=> cmp_a_pos_select_o == $past(pwdata_i[`CR_CMP_POS_A]))
        else $error("comparator a positive select not taken");

    a_ladder_power: assert property (
        (wr && sel == SEL_REF)
            |=> ladder_power_enable_o == $past(pwdata_i[`CR_REF_PWR]))
        else $error("ladder power bit not taken from write");

    a_ladder_pin: assert property (
        (wr && sel == SEL_REF)
            |=> ladder_pin_enable_o == $past(pwdata_i[`CR_REF_PIN]))
        else $error("ladder pin bit not taken from write");

    a_ladder_source: assert property (
        (wr && sel == SEL_REF)
            |=> ladder_source_select_o == $past(pwdata_i[`CR_REF_SRC]))
        else $error("ladder source bit not taken from write");

    a_event_clear: assert property (
        (wr && sel == SEL_CMP && !pwdata_i[`CR_CMP_EVT_A]
            && !sif.change[0]) |=> !q.evt[0])
        else $error("comparator a event flag not cleared");

    a_status_set: assert property (
        (sif.change[0] && !(q.idle_stop && idle_i)) |=> q.irq_stat[0])
        else $error("comparator a change did not set status");

    a_pad_follows: assert property (
        cmp_b_pad_o == $past(sif.result[1]))
        else $error("comparator b pad value does not follow result");

    a_unmapped_error: assert property (
        (psel_i && !penable_i && sel == SEL_NONE) |=> pslverr_o)
        else $error("unmapped address answered without error");

    a_pready_one: assert property (
        (psel_i && !penable_i) |=> pready_o ##1 !pready_o)
        else $error("pready not a single access cycle");

endmodule : cmp_ref_ctrl
`default_nettype wire

// [cmp_analog_model.sv]
// Behavioural analog side: two comparator cores and the reference ladder.
// Assumes pin levels in millivolts from the bench; inputs shared by both.
`default_nettype none
module cmp_analog_model #(
    parameter int RAIL_MV = 3300,
    parameter int EXT_MV  = 2500
) (
    input  wire logic [1:0]  pos_sel_i,
    input  wire logic [1:0]  neg_sel_i,
    input  wire logic        power_i,
    input  wire logic        range_i,
    input  wire logic        source_i,
    input  wire logic [3:0]  code_i,
    input  wire logic [15:0] vinp_mv_i,
    input  wire logic [15:0] vinm_mv_i,
    output logic      [1:0]  raw_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int src_mv;
    int ref_mv;
    int p;
    int n;
    always_comb begin
        src_mv = source_i ? EXT_MV : RAIL_MV;
        if (!power_i) begin
            ref_mv = 0;
        end else if (range_i) begin
            ref_mv = code_i * src_mv / 24;
        end else begin
            ref_mv = src_mv / 4 + code_i * src_mv / 32;
        end
        for (int i = 0; i < 2; i++) begin
            p = pos_sel_i[i] ? int'(vinp_mv_i) : ref_mv;
            n = neg_sel_i[i] ? int'(vinp_mv_i) : int'(vinm_mv_i);
            raw_o[i] = p > n;
        end
    end
endmodule : cmp_analog_model
`default_nettype wire

// [dual_comparator_reference_ctrl_bench.sv]
// Self-checking bench: APB register traffic, events, interrupt, idle.
// Assumes the behavioural analog model closes the comparator loop.
`default_nettype none
`include "cmp_ref_params.svh"
module dual_comparator_reference_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i = 1'h0;
    logic        rst_n_i   = 1'h0;
    logic [11:0] paddr     = 12'h000;
    logic        psel      = 1'h0;
    logic        penable   = 1'h0;
    logic        pwrite    = 1'h0;
    logic        idle      = 1'h0;
    logic [31:0] pwdata    = 32'h0;
    logic [15:0] vinp      = 16'h07D0;
    logic [15:0] vinm      = 16'h03E8;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        irq;
    logic [1:0]  raw;
    logic [1:0]  en;
    logic [1:0]  pos;
    logic [1:0]  neg;
    logic [1:0]  pad;
    logic [1:0]  oe;
    logic [7:0]  lad;
    int          bad_count = 0;
    int          n_checks  = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    cmp_ref_ctrl dut_u (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .idle_i(idle), .cmp_a_raw_i(raw[0]),
        .cmp_b_raw_i(raw[1]), .irq_o(irq), .cmp_a_enable_o(en[0]),
        .cmp_b_enable_o(en[1]), .cmp_a_pos_select_o(pos[0]),
        .cmp_b_pos_select_o(pos[1]), .cmp_a_neg_select_o(neg[0]),
        .cmp_b_neg_select_o(neg[1]), .cmp_a_pad_o(pad[0]),
        .cmp_a_pad_oe_o(oe[0]), .cmp_b_pad_o(pad[1]),
        .cmp_b_pad_oe_o(oe[1]), .ladder_power_enable_o(lad[7]),
        .ladder_pin_enable_o(lad[6]), .ladder_range_select_o(lad[5]),
        .ladder_source_select_o(lad[4]), .ladder_level_code_o(lad[3:0])
    );

    cmp_analog_model model_u (
        .pos_sel_i(pos), .neg_sel_i(neg), .power_i(lad[7]),
        .range_i(lad[5]), .source_i(lad[4]), .code_i(lad[3:0]),
        .vinp_mv_i(vinp), .vinm_mv_i(vinm), .raw_o(raw)
    );

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic timed_out(input string what);
        bad_count++;
        $display("mismatch %s expected response seen none", what);
        tally_and_finish();
    endtask : timed_out

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk_i);
            if (pready === 1'h1) break;
            if (i == 7) timed_out("pready");
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdchk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check(what, exp, rd);
    endtask : rdchk

    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 20; i++) begin
            @(negedge ref_clk_i);
            if (irq === exp) return;
        end
        timed_out("irq");
    endtask : wait_irq

    task automatic t_reset;
        rdchk("cmp", `CR_OFS_CMP, 32'h0);
        rdchk("ref", `CR_OFS_REF, 32'h0);
        rdchk("stat", `CR_OFS_STAT, 32'h0);
        rdchk("mask", `CR_OFS_MASK, 32'h0);
        check("irq", 32'h0, {31'h0, irq});
        $display("test reset done");
    endtask : t_reset

    task automatic t_fields;
        wr(`CR_OFS_CMP, 32'h0000C3FF);
        rdchk("cmp", `CR_OFS_CMP, 32'h0000833F);
        @(negedge ref_clk_i);
        check("pos", 32'h3, {30'h0, pos});
        check("neg", 32'h3, {30'h0, neg});
        check("oe", 32'h3, {30'h0, oe});
        check("en", 32'h0, {30'h0, en});
        wr(`CR_OFS_REF, 32'hFFFFFFFF);
        rdchk("ref", `CR_OFS_REF, 32'h000000FF);
        @(negedge ref_clk_i);
        check("ladder", 32'hFF, {24'h0, lad});
        wr(`CR_OFS_REF, 32'h0000002C);
        @(negedge ref_clk_i);
        check("ladder", 32'h2C, {24'h0, lad});
        wr(12'h010, 32'h0000FFFF);
        check("wr err", 32'h1, {31'h0, err});
        apb(1'h0, 12'h010, 32'h0);
        check("rd err", 32'h1, {31'h0, err});
        check("rd data", 32'h0, rd);
        rdchk("cmp", `CR_OFS_CMP, 32'h0000833F);
        wr(`CR_OFS_CMP, 32'h0);
        $display("test fields done");
    endtask : t_fields

    task automatic clear_all(input logic [31:0] cmp);
        wr(`CR_OFS_CMP, cmp);
        // Routing or invert changes raise events until the sync settles
        repeat (6) @(posedge ref_clk_i);
        wr(`CR_OFS_CMP, cmp);
        wr(`CR_OFS_STAT, 32'h3);
        wait_irq(1'h0);
    endtask : clear_all

    task automatic t_event;
        wr(`CR_OFS_MASK, 32'h3);
        wr(`CR_OFS_CMP, 32'h00000501);
        wait_irq(1'h1);
        rdchk("cmp", `CR_OFS_CMP, 32'h00001541);
        rdchk("stat", `CR_OFS_STAT, 32'h1);
        check("pad", 32'h1, {31'h0, pad[0]});
        clear_all(32'h00000501);
        rdchk("cmp", `CR_OFS_CMP, 32'h00000541);
        wr(`CR_OFS_CMP, 32'h00000511);
        wait_irq(1'h1);
        rdchk("cmp", `CR_OFS_CMP, 32'h00001511);
        clear_all(32'h00000500);
        wr(`CR_OFS_REF, 32'h000000AC);
        wait_irq(1'h1);
        rdchk("cmp", `CR_OFS_CMP, 32'h00001540);
        clear_all(32'h00000540);
        $display("test event done");
    endtask : t_event

    task automatic t_idle;
        wr(`CR_OFS_CMP, 32'h00008501);
        @(posedge ref_clk_i);
        idle <= 1'h1;
        vinp <= 16'h01F4;
        repeat (8) @(negedge ref_clk_i);
        check("irq", 32'h0, {31'h0, irq});
        rdchk("stat", `CR_OFS_STAT, 32'h0);
        rdchk("cmp", `CR_OFS_CMP, 32'h00009501);
        @(posedge ref_clk_i);
        idle <= 1'h0;
        vinp <= 16'h07D0;
        wait_irq(1'h1);
        $display("test idle done");
    endtask : t_idle

    task automatic t_cmp_b;
        clear_all(32'h00000A0C);
        rdchk("cmp", `CR_OFS_CMP, 32'h00000A0C);
        wr(`CR_OFS_CMP, 32'h00000A04);
        wait_irq(1'h1);
        rdchk("cmp", `CR_OFS_CMP, 32'h00002A84);
        rdchk("stat", `CR_OFS_STAT, 32'h2);
        check("pad", 32'h1, {31'h0, pad[1]});
        check("oe", 32'h2, {30'h0, oe});
        check("en", 32'h2, {30'h0, en});
        wr(`CR_OFS_MASK, 32'h1);
        @(negedge ref_clk_i);
        check("irq", 32'h0, {31'h0, irq});
        $display("test comparator b done");
    endtask : t_cmp_b

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'h1;
        t_reset();
        t_fields();
        t_event();
        t_idle();
        t_cmp_b();
        tally_and_finish();
    end
endmodule : dual_comparator_reference_ctrl_bench
`default_nettype wire
